// file: aisrc_top.sv
`timescale 1ns/1ps
// Operation
// - Seven-bit watermark; flag when level reached
// - Set routing bit drives event onto pin
// - Bits 7..4 route events to pin b
// - Bits 3..0 route events to pin a
// - Timing bit 2 selects outside sample clock
// - Code 00 internal; 01 ready on trigger
// - Code 10 ready 14..8204 cycles after trigger
// - Polarity bit 6: 0 low, 1 high
module aisrc_top #(
  parameter int INTERP_MIN_CYC = 14,
  parameter int INTERP_MAX_CYC = 8204,
  parameter int SAMPLE_BASE_CYC = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic outside_clk,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic trigger_pin,
  input wire logic motion_event,
  input wire logic buffer_overrun,
  input wire logic [6:0] fifo_level,
  input wire logic [3:0] rate_filter_setting,
  output logic data_ready,
  output logic watermark_hit,
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic [1:0] range_code,
  output logic bus_high_speed_select,
  output logic standby,
  output logic temp_off
);
  typedef enum logic {ST_IDLE, ST_DELAY} aisrc_interp_type;

  localparam int DLY_STEP =
    (INTERP_MAX_CYC - INTERP_MIN_CYC) / aisrc_pkg::RATE_STEPS;

  function automatic logic route_any(input logic [3:0] en,
                                     input logic [3:0] ev);
    route_any = |(en & ev);
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] watermark_q, routing_q, timing_q, span_q, power_q;
  logic [7:0] rdata_q, rdata_d;
  logic wr_wm, wr_route, wr_timing, wr_span, wr_power;

  assign wr_wm = reg_wr && reg_addr == aisrc_pkg::OFS_WATERMARK;
  assign wr_route = reg_wr && reg_addr == aisrc_pkg::OFS_ROUTING;
  assign wr_timing = reg_wr && reg_addr == aisrc_pkg::OFS_TIMING;
  assign wr_span = reg_wr && reg_addr == aisrc_pkg::OFS_SPAN;
  assign wr_power = reg_wr && reg_addr == aisrc_pkg::OFS_POWER;

  // Reserved bits never store, so they read as zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watermark_q <= aisrc_pkg::RST_WATERMARK;
      routing_q <= aisrc_pkg::RST_ROUTING;
      timing_q <= aisrc_pkg::RST_TIMING;
      span_q <= aisrc_pkg::RST_SPAN;
      power_q <= aisrc_pkg::RST_POWER;
    end else begin
      if (wr_wm) watermark_q <= reg_wdata & aisrc_pkg::MASK_WATERMARK;
      if (wr_route) routing_q <= reg_wdata;
      if (wr_timing) timing_q <= reg_wdata & aisrc_pkg::MASK_TIMING;
      if (wr_span) span_q <= reg_wdata & aisrc_pkg::MASK_SPAN;
      if (wr_power) power_q <= reg_wdata & aisrc_pkg::MASK_POWER;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      aisrc_pkg::OFS_WATERMARK: rdata_d = watermark_q;
      aisrc_pkg::OFS_ROUTING: rdata_d = routing_q;
      aisrc_pkg::OFS_TIMING: rdata_d = timing_q;
      aisrc_pkg::OFS_SPAN: rdata_d = span_q;
      aisrc_pkg::OFS_POWER: rdata_d = power_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) rdata_q <= 8'h00;
    else if (reg_rd) rdata_q <= rdata_d;
  end
  assign reg_rdata = rdata_q;

  logic outside_clock_select, irq_polarity, stby, drdy_off;
  logic [1:0] trigger_sync_mode;
  assign outside_clock_select = timing_q[aisrc_pkg::BIT_OUTSIDE_CLK];
  assign trigger_sync_mode = timing_q[1:0];
  assign irq_polarity = span_q[aisrc_pkg::BIT_POLARITY];
  assign stby = power_q[aisrc_pkg::BIT_STANDBY];
  assign drdy_off = power_q[aisrc_pkg::BIT_DRDY_OFF];
  assign range_code = span_q[1:0];
  assign bus_high_speed_select = span_q[aisrc_pkg::BIT_HIGH_SPEED];
  assign standby = stby;
  assign temp_off = power_q[aisrc_pkg::BIT_TEMP_OFF];

  // ==========================================================
  // Outside clock domain: divider producing a sample toggle
  logic orst_s1_q, orst_s2_q, osel_s1_q, osel_s2_q, otog_q;
  logic [7:0] odiv_q;
  always_ff @(posedge outside_clk) begin
    orst_s1_q <= rst;
    orst_s2_q <= orst_s1_q;
    osel_s1_q <= outside_clock_select;
    osel_s2_q <= osel_s1_q;
  end

  // Stalls harmlessly when the outside clock is absent
  always_ff @(posedge outside_clk) begin
    if (orst_s2_q || !osel_s2_q) begin
      odiv_q <= 8'h00;
      otog_q <= 1'b0;
    end else if (odiv_q == aisrc_pkg::OUTSIDE_DIV) begin
      odiv_q <= 8'h00;
      otog_q <= ~otog_q;
    end else begin
      odiv_q <= odiv_q + 8'h01;
    end
  end

  // ==========================================================
  // Crossings and pin sampling in the oscillator domain
  logic tog_s1_q, tog_s2_q, tog_s3_q, trg_s1_q, trg_s2_q, trg_s3_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= otog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      trg_s1_q <= trigger_pin;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  logic outside_tick, trig_rise;
  assign outside_tick = tog_s2_q ^ tog_s3_q;
  assign trig_rise = trg_s2_q & ~trg_s3_q;

  // ==========================================================
  // Internal sample timer and interpolation delay
  logic [3:0] rate_eff;
  logic [aisrc_pkg::CNT_W-1:0] int_cnt_q, period, interp_load, dly_q;
  logic int_tick;
  aisrc_interp_type ist_q;

  assign rate_eff = (rate_filter_setting > aisrc_pkg::RATE_MAX) ?
                    aisrc_pkg::RATE_MAX : rate_filter_setting;
  assign period = aisrc_pkg::CNT_W'(SAMPLE_BASE_CYC) << rate_eff;
  assign int_tick = int_cnt_q == period - 1'b1;
  // Delay grows linearly with the rate code, min at 0 and max at 10
  assign interp_load = aisrc_pkg::CNT_W'(INTERP_MIN_CYC - 1)
                     + aisrc_pkg::CNT_W'(DLY_STEP)
                     * aisrc_pkg::CNT_W'(rate_eff);

  always_ff @(posedge ref_clk) begin
    if (rst || stby || int_tick) int_cnt_q <= '0;
    else int_cnt_q <= int_cnt_q + 1'b1;
  end

  logic interp_fire;
  assign interp_fire = ist_q == ST_DELAY && dly_q == '0;

  // A new trigger during the wait restarts it
  always_ff @(posedge ref_clk) begin
    if (rst || stby || trigger_sync_mode != aisrc_pkg::SYNC_INTERP) begin
      ist_q <= ST_IDLE;
      dly_q <= '0;
    end else if (trig_rise) begin
      ist_q <= ST_DELAY;
      dly_q <= interp_load;
    end else begin
      case (ist_q)
        ST_IDLE: dly_q <= '0;
        ST_DELAY: begin
          if (dly_q == '0) ist_q <= ST_IDLE;
          else dly_q <= dly_q - 1'b1;
        end
        default: ist_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Data ready selection
  logic sample_tick, ready_event, drdy_q, wm_q;
  assign sample_tick = outside_clock_select ? outside_tick : int_tick;

  always_comb begin
    case (trigger_sync_mode)
      aisrc_pkg::SYNC_INTERNAL: ready_event = sample_tick;
      aisrc_pkg::SYNC_DIRECT: ready_event = trig_rise;
      aisrc_pkg::SYNC_INTERP: ready_event = interp_fire;
      default: ready_event = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drdy_q <= 1'b0;
      wm_q <= 1'b0;
    end else begin
      drdy_q <= ready_event & ~stby & ~drdy_off;
      wm_q <= fifo_level >= watermark_q[6:0];
    end
  end
  assign data_ready = drdy_q;
  assign watermark_hit = wm_q;

  // ==========================================================
  // Interrupt pins
  logic [3:0] events;
  logic [1:0] irq_q;
  assign events = {motion_event, buffer_overrun, wm_q, drdy_q};

  // Pins idle high out of reset since polarity resets to active low
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      logic act;
      assign act = route_any(routing_q[gi*4 +: 4], events);
      always_ff @(posedge ref_clk) begin
        if (rst) irq_q[gi] <= 1'b1;
        else irq_q[gi] <= ~(act ^ irq_polarity);
      end
    end
  endgenerate
  assign irq_pin_a = irq_q[0];
  assign irq_pin_b = irq_q[1];

  // ==========================================================
  // Checks
  a_standby_quiet: assert property (
    @(posedge ref_clk) disable iff (rst)
    stby |=> !drdy_q)
    else $error("ready pulsed in standby");
  a_direct_sync: assert property (
    @(posedge ref_clk) disable iff (rst)
    (trigger_sync_mode == aisrc_pkg::SYNC_DIRECT && trig_rise && !stby
     && !drdy_off) |=> drdy_q)
    else $error("no ready on trigger");
  a_interp_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    (trigger_sync_mode == aisrc_pkg::SYNC_INTERP && trig_rise)
    |=> !drdy_q [*8])
    else $error("interpolated ready too early");
  a_interp_load: assert property (
    @(posedge ref_clk) disable iff (rst)
    (trigger_sync_mode == aisrc_pkg::SYNC_INTERP && trig_rise && !stby)
    |=> ist_q == ST_DELAY && dly_q == $past(interp_load))
    else $error("delay not loaded");
  a_pin_a_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> irq_pin_a == ~(|($past(routing_q[3:0]) & $past(events))
    ^ $past(irq_polarity)))
    else $error("pin a mismatch");
  a_pin_b_full: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1 |=> irq_pin_b == ~(|($past(routing_q[7:4]) & $past(events))
    ^ $past(irq_polarity)))
    else $error("pin b mismatch");
  a_pin_b_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    ($past(routing_q[7:4]) == 4'h0) |-> irq_pin_b == ~$past(irq_polarity))
    else $error("pin b active with no routing");
  a_ready_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    (drdy_q && routing_q[aisrc_pkg::EV_READY])
    |=> irq_pin_a == $past(irq_polarity))
    else $error("ready not routed to pin a");
  a_watermark_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fifo_level < watermark_q[6:0]) |=> !wm_q)
    else $error("watermark early");
  a_watermark_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    (fifo_level >= watermark_q[6:0]) |=> wm_q)
    else $error("watermark missed");
  a_outside_clock: assert property (
    @(posedge ref_clk) disable iff (rst)
    (outside_clock_select && trigger_sync_mode == aisrc_pkg::SYNC_INTERNAL
     && !outside_tick) |=> !drdy_q)
    else $error("ready off outside clock");
  a_span_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_span |=> range_code == $past(reg_wdata[1:0])
    && bus_high_speed_select == $past(reg_wdata[7]))
    else $error("span write lost");
  a_polarity_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    (events == 4'h0) [*2] |-> irq_pin_a == ~$past(irq_polarity))
    else $error("idle level wrong");
endmodule // aisrc_top

// file: aisrc_pkg.sv
package aisrc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_WATERMARK = 8'h29;
  localparam logic [7:0] OFS_ROUTING = 8'h2A;
  localparam logic [7:0] OFS_TIMING = 8'h2B;
  localparam logic [7:0] OFS_SPAN = 8'h2C;
  localparam logic [7:0] OFS_POWER = 8'h2D;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_WATERMARK = 8'h60;
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_SPAN = 8'h81;
  localparam logic [7:0] RST_POWER = 8'h01;
  // ==========================================================
  // Writable bits and field positions
  localparam logic [7:0] MASK_WATERMARK = 8'h7F;
  localparam logic [7:0] MASK_TIMING = 8'h07;
  localparam logic [7:0] MASK_SPAN = 8'hC3;
  localparam logic [7:0] MASK_POWER = 8'h07;
  localparam int BIT_OUTSIDE_CLK = 2;
  localparam int BIT_POLARITY = 6;
  localparam int BIT_HIGH_SPEED = 7;
  localparam int BIT_STANDBY = 0;
  localparam int BIT_TEMP_OFF = 1;
  localparam int BIT_DRDY_OFF = 2;
  // Event order within one pin's routing nibble
  localparam int EV_READY = 0;
  localparam int EV_WATERMARK = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_MOTION = 3;
  // ==========================================================
  // Synchronization codes
  localparam logic [1:0] SYNC_INTERNAL = 2'h0;
  localparam logic [1:0] SYNC_DIRECT = 2'h1;
  localparam logic [1:0] SYNC_INTERP = 2'h2;
  // ==========================================================
  // Timing
  localparam logic [3:0] RATE_MAX = 4'hA;
  localparam int RATE_STEPS = 10;
  localparam logic [7:0] OUTSIDE_DIV = 8'h0F;
  localparam int CNT_W = 20;
endpackage

// file: aisrc_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: register strobes and the sync trigger pin
module aisrc_host (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic trigger_pin
);
  logic [7:0] exp_q[$];
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    trigger_pin = 1'b0;
  end
  // Released bus shows inverted values, never a stale copy
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // Callers keep reserved codes out and change setup in standby
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    idle();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge ref_clk);
    idle();
  endtask
  task automatic trig();
    @(negedge ref_clk);
    trigger_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    trigger_pin = 1'b0;
  endtask
endmodule // aisrc_host

// file: test_aisrc_top.sv
`timescale 1ns/1ps
module test_aisrc_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic outside_clk = 1'b0;
  logic oc_en = 1'b1;
  logic reg_wr, reg_rd, trigger_pin, data_ready, watermark_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic motion_event = 1'b0;
  logic buffer_overrun = 1'b0;
  logic [6:0] fifo_level = 7'h00;
  logic [3:0] rate_filter_setting = 4'h0;
  logic irq_pin_a, irq_pin_b, bus_high_speed_select, standby, temp_off;
  logic [1:0] range_code;
  logic rd_seen = 1'b0;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 24268;
  logic [7:0] ofs[5] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
  logic [7:0] msk[5] = '{8'h7F, 8'hFF, 8'h07, 8'hC3, 8'h07};
  // Legal random bits: watermark 1..63, sync code 01 only, no reserved bits
  logic [7:0] lgl[5] = '{8'h3F, 8'hFF, 8'h05, 8'hC3, 8'h07};
  logic [7:0] d;
  always #20 ref_clk = ~ref_clk;
  // Outside clock runs through reset and then only while a test opens it
  always #6 if (oc_en) outside_clk = ~outside_clk;
  aisrc_host i_aisrc_host (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .trigger_pin(trigger_pin));
  aisrc_top #(.INTERP_MAX_CYC(114), .SAMPLE_BASE_CYC(4)) i_aisrc_top (
    .ref_clk(ref_clk), .rst(rst), .outside_clk(outside_clk),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .trigger_pin(trigger_pin), .motion_event(motion_event),
    .buffer_overrun(buffer_overrun), .fifo_level(fifo_level),
    .rate_filter_setting(rate_filter_setting), .data_ready(data_ready),
    .watermark_hit(watermark_hit), .irq_pin_a(irq_pin_a),
    .irq_pin_b(irq_pin_b), .range_code(range_code),
    .bus_high_speed_select(bus_high_speed_select), .standby(standby),
    .temp_off(temp_off));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d of %0d checks", bad_count, num_checks);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Oldest read note against the data that the read returned
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1)
      check(reg_rdata, i_aisrc_host.exp_q.pop_front());
  end
  // Cycles from now until a ready pulse, compared against a window
  task automatic ready_in(input int lo, input int hi);
    int n;
    n = 0;
    while (data_ready !== 1'b1 && n <= hi + 4) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask
  task automatic pins(input logic a, input logic b);
    repeat (3) @(negedge ref_clk);
    check({6'h00, irq_pin_a, irq_pin_b}, {6'h00, a, b});
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    oc_en = 1'b0;
    foreach (ofs[i]) i_aisrc_host.rd(ofs[i], i == 0 ? 8'h60 :
      i == 3 ? 8'h81 : i == 4 ? 8'h01 : 8'h00);
    i_aisrc_host.rd(8'h30, 8'h00);
    check({3'h0, range_code, bus_high_speed_select, standby, temp_off},
      8'h0E);
    check({irq_pin_a, irq_pin_b}, 8'h03);
    foreach (ofs[i]) begin
      d = 8'($random(seed));
      d = (d & lgl[i]) | 8'h01;
      i_aisrc_host.wr(ofs[i], d);
      i_aisrc_host.rd(ofs[i], d & msk[i]);
    end
    check({6'h00, temp_off, standby}, {6'h00, d[1], 1'b1});
    i_aisrc_host.wr(8'h2D, 8'h01);
    i_aisrc_host.wr(8'h2C, 8'h43);
    check({range_code, bus_high_speed_select}, 8'h06);
    i_aisrc_host.wr(8'h2C, 8'h01);
    i_aisrc_host.wr(8'h29, 8'h60);
    fifo_level = 7'h5F;
    pins(1'b1, 1'b1);
    check({7'h00, watermark_hit}, 8'h00);
    // Each routing bit but 0 and 4 alone: only its event on only its pin
    for (int b = 1; b < 8; b++) begin
      if (b == 4) continue;
      i_aisrc_host.wr(8'h2A, 8'h01 << b);
      motion_event = (b % 4) == 3;
      buffer_overrun = (b % 4) == 2;
      fifo_level = (b % 4) == 1 ? 7'h60 : 7'h5F;
      pins(b > 3, b < 4);
      check({7'h00, watermark_hit}, {7'h00, fifo_level == 7'h60});
    end
    i_aisrc_host.wr(8'h2A, 8'hE6);
    i_aisrc_host.wr(8'h2C, 8'h41);
    pins(1'b0, 1'b1);
    motion_event = 1'b0;
    pins(1'b0, 1'b0);
    i_aisrc_host.wr(8'h2A, 8'h00);
    i_aisrc_host.wr(8'h2C, 8'h01);
    i_aisrc_host.wr(8'h2B, 8'h01);
    i_aisrc_host.wr(8'h2D, 8'h00);
    fork i_aisrc_host.trig(); join_none
    ready_in(2, 4);
    for (int r = 0; r <= 10; r += 5) begin
      i_aisrc_host.wr(8'h2D, 8'h01);
      i_aisrc_host.wr(8'h2B, 8'h02);
      rate_filter_setting = 4'(r);
      i_aisrc_host.wr(8'h2D, 8'h00);
      fork i_aisrc_host.trig(); join_none
      ready_in(14 + 10 * r, 20 + 10 * r);
    end
    i_aisrc_host.wr(8'h2D, 8'h01);
    i_aisrc_host.wr(8'h2B, 8'h04);
    rate_filter_setting = 4'h0;
    i_aisrc_host.wr(8'h2D, 8'h00);
    // Outside clock stopped: no ready may appear
    repeat (60) begin
      @(negedge ref_clk);
      check({7'h00, data_ready}, 8'h00);
    end
    oc_en = 1'b1;
    ready_in(1, 40);
    oc_en = 1'b0;
    i_aisrc_host.wr(8'h2D, 8'h01);
    i_aisrc_host.wr(8'h2B, 8'h00);
    i_aisrc_host.wr(8'h2A, 8'h11);
    i_aisrc_host.wr(8'h2D, 8'h00);
    ready_in(1, 12);
    @(negedge ref_clk);
    check({irq_pin_a, irq_pin_b}, 8'h00);
    repeat (4) @(negedge ref_clk);
    test_done();
  end
endmodule // test_aisrc_top
